// ===== thermal_map_pkg.sv
// Purpose: Shared constants and carriers for the module memory map block.
// Assumes: Byte-wide access from a serial protocol engine on the same clock.
// Notes: Offsets are byte addresses within the 256-byte serial window.
package thermal_map_pkg;
    localparam int unsigned PAGE_BYTES = 128;
    localparam logic [7:0] OFS_MODULE_TYPE = 8'h00;
    localparam logic [7:0] OFS_TEMP_HIGH = 8'h16;
    localparam logic [7:0] OFS_TEMP_LOW = 8'h17;
    localparam logic [7:0] OFS_RW_FIRST = 8'h56;
    localparam logic [7:0] OFS_POWER_CTRL = 8'h5D;
    localparam logic [7:0] OFS_HEATER = 8'h62;
    localparam logic [7:0] OFS_PAGE_SEL = 8'h7F;
    localparam logic [7:0] OFS_UPPER_ID = 8'h80;
    localparam logic [7:0] OFS_PLUG_LOW = 8'h8D;
    localparam logic [7:0] OFS_PLUG_HIGH = 8'h8E;
    localparam logic [7:0] PAGE_ID = 8'h00;
    localparam logic [7:0] PAGE_USER = 8'h02;
    localparam logic [7:0] PAGE_EXTRA = 8'h03;
    localparam int unsigned BIT_OVERRIDE = 0;
    localparam int unsigned BIT_POWER_SET = 1;
    localparam int unsigned BIT_SPOT_LO = 6;
    localparam int unsigned BIT_SPOT_HI = 7;
    localparam logic [7:0] RST_PAGE_SEL = 8'h00;
    localparam logic [7:0] RST_POWER_CTRL = 8'h00;
    localparam logic [15:0] RST_TEMP = 16'h0000;
    localparam logic signed [7:0] CUTOFF_DEG = 8'sd80;
    localparam logic signed [7:0] HYST_DEG = 8'sd5;
    localparam logic signed [7:0] RESTORE_DEG = CUTOFF_DEG - HYST_DEG;
    localparam logic [5:0] PWM_FULL = 6'h3F;

    // One byte access request from the serial engine.
    typedef struct packed {
        logic addr_load;
        logic [7:0] addr_value;
        logic wr_stb;
        logic [7:0] wr_data;
        logic rd_stb;
    } acc_req_s;

    // Heater drive lines toward the power stage.
    typedef struct packed {
        logic pwm;
        logic spot_lo;
        logic spot_hi;
    } heat_drive_s;

    // Start-up sequence states, Gray coded along the path.
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_SAVE = 2'b01,
        ST_RUN = 2'b11
    } init_state_e;
endpackage

// ===== thermal_map_regs.sv
// Contract
// - One lower page plus shared upper pages.
// - Byte 127 selects the mapped upper page.
// - Lower page, pages 00, 03 always present.
// - Page 02 user storage, page 01 table; page 01 not mapped here, reads zero.
// - Lower bytes 0 to 85 are read-only.
// - Lower bytes 86 to 127 are read/write.
// - Byte 0 mirrors upper page 00 byte 128.
// - Latest temperature in bytes 22 and 23.
// - Temperature signed, one 256th degree per LSB.
// - Count each start-up into nonvolatile storage.
// - Count readable at page 2 bytes 141-142.
// - Byte 98 steers power in high-power only.
// - Low-power mode forces all heaters off.
// - Heater byte saved and restored nonvolatile.
// - Bits 5:0 set linear PWM duty.
// - Bit 6 switches 1.5 W spot.
// - Bit 7 switches 2.5 W spot.
// - Heaters off at 80 degrees or more.
// - Heaters return at five degrees below.
// - Low power from pin or override bits.
// - Address counter wraps within its page.
//
// Purpose: Memory map, heater control and thermal cut-off of a test module.
// Assumes: Serial engine, sensor and NV store share clk; the pin does not.
// Notes: The PWM period is 63 clocks so code 63 is a steady full drive.
`timescale 1ns/1ps
module thermal_map_regs
    import thermal_map_pkg::*;
#(
    parameter logic [7:0] MODULE_TYPE = 8'h5A // Arbitrary type code value.
) (
    input wire logic clk, // 20 MHz system clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire acc_req_s acc, // Byte access request from serial engine.
    output logic [7:0] rd_data, // Read byte, registered.
    output logic rd_valid, // One-cycle pulse with rd_data.
    input wire logic [15:0] temp_sample, // Sensor reading, 1/256 degree LSB.
    input wire logic temp_valid, // Pulse: new sensor reading.
    input wire logic low_power_request_pin, // Asynchronous pin level.
    input wire logic [7:0] nv_heater_in, // Stored heater byte.
    input wire logic [15:0] nv_count_in, // Stored insertion count.
    output logic nv_save, // One-cycle pulse: store nv outputs.
    output logic [7:0] nv_heater_out, // Heater byte to store.
    output logic [15:0] nv_count_out, // Insertion count to store.
    output heat_drive_s heat, // Heater drive lines.
    output logic low_power_mode, // Module is in low-power mode.
    output logic cutoff_active, // Thermal cut-off is holding heaters off.
    output logic init_done // Start-up sequence finished.
);
    // Storage for the plain read/write bytes of the map.
    logic [7:0] lower_mem [0:PAGE_BYTES-1]; // Lower bytes, only 86 to 127 used.
    logic [7:0] user_mem [0:PAGE_BYTES-1]; // Page 02 user storage.
    logic [7:0] extra_mem [0:PAGE_BYTES-1]; // Page 03 storage.

    init_state_e state_reg, state_next; // Start-up sequence state.
    logic [7:0] addr_reg; // Internal byte address counter.
    logic [7:0] page_sel_reg; // Selected upper page.
    logic [7:0] power_ctrl_reg; // Power override control byte.
    logic [7:0] heater_reg; // Heater control byte.
    logic [15:0] count_reg; // Insertion count.
    logic [15:0] temp_reg; // Latest temperature reading.
    logic [1:0] lp_sync_reg; // Pin synchroniser chain.
    logic cutoff_reg; // Cut-off latch.
    logic [5:0] pwm_cnt_reg; // PWM phase counter, 0 to 62.
    logic nv_save_reg; // Store request pulse.
    logic [7:0] rd_data_reg; // Read data holding register.
    logic rd_valid_reg; // Read data valid pulse.
    heat_drive_s heat_reg; // Registered heater drive.

    // Decode of the current address.
    wire logic is_upper = addr_reg[7];
    wire logic [6:0] low_idx = addr_reg[6:0];
    wire logic [7:0] addr_inc = {addr_reg[7], low_idx + 7'h01};
    wire logic busy = (state_reg != ST_RUN);
    wire logic do_wr = acc.wr_stb && !busy;
    wire logic do_rd = acc.rd_stb && !busy && !acc.wr_stb;
    wire logic pg_id = is_upper && (page_sel_reg == PAGE_ID);
    wire logic pg_user = is_upper && (page_sel_reg == PAGE_USER);
    wire logic pg_extra = is_upper && (page_sel_reg == PAGE_EXTRA);
    wire logic lower_rw = !is_upper && (addr_reg >= OFS_RW_FIRST);
    wire logic user_ro = (addr_reg == OFS_PLUG_LOW) || (addr_reg == OFS_PLUG_HIGH);

    // Writes land only in writable bytes; all others are dropped.
    wire logic wr_page_sel = do_wr && (addr_reg == OFS_PAGE_SEL);
    wire logic wr_power = do_wr && (addr_reg == OFS_POWER_CTRL);
    wire logic wr_heater = do_wr && (addr_reg == OFS_HEATER);
    wire logic wr_lower = do_wr && lower_rw;
    wire logic wr_user = do_wr && pg_user && !user_ro;
    wire logic wr_extra = do_wr && pg_extra;

    // Power mode: override bits win over the pin when override is set.
    wire logic override_on = power_ctrl_reg[BIT_OVERRIDE];
    wire logic lp_now = override_on ? power_ctrl_reg[BIT_POWER_SET]
                                    : lp_sync_reg[1];

    // Cut-off works on whole signed degrees only.
    // Drive follows the next latch value, so heaters drop one clock after a hot reading.
    // A reading that jumps straight below the band releases at once, which is intended.
    wire logic signed [7:0] temp_deg = temp_reg[15:8];
    wire logic hot = temp_deg >= CUTOFF_DEG;
    wire logic cooled = temp_deg <= RESTORE_DEG;
    wire logic cutoff_next = hot || (cutoff_reg && !cooled);
    wire logic drive_ok = !lp_now && !cutoff_next;

    // PWM compare: code 0 never on, code 63 always on over a 63-step period.
    wire logic [5:0] pwm_cnt_next = (pwm_cnt_reg == PWM_FULL - 6'h01)
                                    ? 6'h00 : pwm_cnt_reg + 6'h01;
    wire logic pwm_on = pwm_cnt_reg < heater_reg[5:0];
    // One assignment for the whole carrier, so it has a single driver.
    heat_drive_s heat_next;
    assign heat_next = '{
        pwm: drive_ok && pwm_on,
        spot_lo: drive_ok && heater_reg[BIT_SPOT_LO],
        spot_hi: drive_ok && heater_reg[BIT_SPOT_HI]
    };

    // Read multiplexer over the whole map.
    logic [7:0] rd_next;
    always_comb begin
        rd_next = 8'h00; // Unimplemented and reserved bytes read zero.
        if (!is_upper) begin
            if (addr_reg == OFS_MODULE_TYPE) begin
                rd_next = MODULE_TYPE;
            end else if (addr_reg == OFS_TEMP_HIGH) begin
                rd_next = temp_reg[15:8];
            end else if (addr_reg == OFS_TEMP_LOW) begin
                rd_next = temp_reg[7:0];
            end else if (addr_reg == OFS_POWER_CTRL) begin
                rd_next = power_ctrl_reg;
            end else if (addr_reg == OFS_HEATER) begin
                rd_next = heater_reg;
            end else if (addr_reg == OFS_PAGE_SEL) begin
                rd_next = page_sel_reg;
            end else if (lower_rw) begin
                rd_next = lower_mem[low_idx];
            end
        end else if (pg_id) begin
            rd_next = (addr_reg == OFS_UPPER_ID) ? MODULE_TYPE : 8'h00;
        end else if (pg_user) begin
            if (addr_reg == OFS_PLUG_LOW) begin
                rd_next = count_reg[7:0];
            end else if (addr_reg == OFS_PLUG_HIGH) begin
                rd_next = count_reg[15:8];
            end else begin
                rd_next = user_mem[low_idx];
            end
        end else if (pg_extra) begin
            rd_next = extra_mem[low_idx];
        end
    end

    // Start-up: fetch stored values, count this insertion, save back.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_LOAD: state_next = ST_SAVE;
            ST_SAVE: state_next = ST_RUN;
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_LOAD;
        endcase
    end

    // Pin synchroniser; only the second stage feeds logic.
    always_ff @(posedge clk) begin
        if (reset) begin
            lp_sync_reg <= 2'b00;
        end else begin
            lp_sync_reg <= {lp_sync_reg[0], low_power_request_pin};
        end
    end

    // Sequence state and nonvolatile values.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_LOAD;
            heater_reg <= 8'h00;
            count_reg <= 16'h0000;
            nv_save_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            nv_save_reg <= (state_reg == ST_LOAD) || wr_heater;
            if (state_reg == ST_LOAD) begin
                heater_reg <= nv_heater_in;
                count_reg <= nv_count_in + 16'h0001;
            end else if (wr_heater) begin
                heater_reg <= acc.wr_data;
            end
        end
    end

    // Address counter, page selector and control byte.
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_reg <= 8'h00;
            page_sel_reg <= RST_PAGE_SEL;
            power_ctrl_reg <= RST_POWER_CTRL;
        end else begin
            if (acc.addr_load && !busy) begin
                addr_reg <= acc.addr_value;
            end else if (do_wr || do_rd) begin
                addr_reg <= addr_inc;
            end
            if (wr_page_sel) begin
                page_sel_reg <= acc.wr_data;
            end
            if (wr_power) begin
                power_ctrl_reg <= acc.wr_data;
            end
        end
    end

    // Plain storage bytes; no reset, they behave as memory.
    always_ff @(posedge clk) begin
        if (wr_lower) begin
            lower_mem[low_idx] <= acc.wr_data;
        end
        if (wr_user) begin
            user_mem[low_idx] <= acc.wr_data;
        end
        if (wr_extra) begin
            extra_mem[low_idx] <= acc.wr_data;
        end
    end

    // Sensor capture, cut-off latch, PWM and registered drive.
    always_ff @(posedge clk) begin
        if (reset) begin
            temp_reg <= RST_TEMP;
            cutoff_reg <= 1'b0;
            pwm_cnt_reg <= 6'h00;
            heat_reg <= '0;
        end else begin
            if (temp_valid) begin
                temp_reg <= temp_sample;
            end
            cutoff_reg <= cutoff_next;
            pwm_cnt_reg <= pwm_cnt_next;
            heat_reg <= heat_next;
        end
    end

    // Read data is registered so the engine sees a stable byte.
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= do_rd;
            if (do_rd) begin
                rd_data_reg <= rd_next;
            end
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign nv_save = nv_save_reg;
    assign nv_heater_out = heater_reg;
    assign nv_count_out = count_reg;
    assign heat = heat_reg;
    assign low_power_mode = lp_now;
    assign cutoff_active = cutoff_reg;
    assign init_done = !busy;

    // Checks on the behaviour above.
    sequence s_heater_write;
        wr_heater ##1 nv_save;
    endsequence

    property p_heater_saved;
        @(posedge clk) disable iff (reset)
        wr_heater |-> s_heater_write ##0 (nv_heater_out == $past(acc.wr_data));
    endproperty
    a_heater_saved: assert property (p_heater_saved)
        else $error("Heater byte not saved after write.");

    property p_count_up;
        @(posedge clk) disable iff (reset)
        (state_reg == ST_LOAD) |=> (count_reg == $past(nv_count_in) + 16'h0001)
            ##1 (count_reg == $past(count_reg));
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("Insertion count not advanced by one.");

    property p_hot_cut;
        @(posedge clk) disable iff (reset)
        hot |=> cutoff_reg && (heat == 3'b000);
    endproperty
    a_hot_cut: assert property (p_hot_cut)
        else $error("Heaters not cut at cut-off temperature.");

    property p_hyst_hold;
        @(posedge clk) disable iff (reset)
        cutoff_reg && (temp_deg > RESTORE_DEG) |=> cutoff_reg;
    endproperty
    a_hyst_hold: assert property (p_hyst_hold)
        else $error("Cut-off released inside hysteresis band.");

    property p_low_power_off;
        @(posedge clk) disable iff (reset)
        lp_now [*2] |-> (heat == 3'b000);
    endproperty
    a_low_power_off: assert property (p_low_power_off)
        else $error("Heater driven in low-power mode.");

    property p_spot_hi;
        @(posedge clk) disable iff (reset)
        drive_ok && heater_reg[BIT_SPOT_HI] |=> heat.spot_hi;
    endproperty
    a_spot_hi: assert property (p_spot_hi)
        else $error("High spot not on when commanded.");

    property p_pwm_full;
        @(posedge clk) disable iff (reset)
        drive_ok && (heater_reg[5:0] == PWM_FULL) |=> heat.pwm;
    endproperty
    a_pwm_full: assert property (p_pwm_full)
        else $error("Full PWM code not fully on.");

    property p_wrap;
        @(posedge clk) disable iff (reset)
        (do_wr || do_rd) && !acc.addr_load && (low_idx == 7'h7F)
            |=> (addr_reg == {$past(addr_reg[7]), 7'h00});
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Address counter left its page.");

    property p_ro_count;
        @(posedge clk) disable iff (reset)
        do_wr && ((pg_user && user_ro) || (!is_upper && !lower_rw))
            |-> !(wr_lower || wr_user || wr_heater || wr_power || wr_page_sel);
    endproperty
    a_ro_count: assert property (p_ro_count)
        else $error("Read-only count byte changed by write.");

    property p_temp_read;
        @(posedge clk) disable iff (reset)
        do_rd && (addr_reg == OFS_TEMP_HIGH)
            |=> rd_valid && (rd_data == $past(temp_reg[15:8]));
    endproperty
    a_temp_read: assert property (p_temp_read)
        else $error("Temperature high byte read wrong.");
endmodule

// ===== nv_store_model.sv
// Purpose: Behavioural model of the nonvolatile store beside the memory map.
// Assumes: A save request is a one-cycle pulse on the system clock.
// Notes: Contents survive reset because only power-up loads the initial count.
`timescale 1ns/1ps
module nv_store_model #(
    parameter logic [15:0] INIT_COUNT = 16'h0100 // Count held before first power-up.
) (
    input wire logic clk, // System clock.
    input wire logic nv_save, // Store request pulse.
    input wire logic [7:0] heater_out, // Heater byte to keep.
    input wire logic [15:0] count_out, // Insertion count to keep.
    output logic [7:0] heater_in, // Kept heater byte.
    output logic [15:0] count_in // Kept insertion count.
);
    // Power-up contents; a later design reset does not touch them.
    initial begin
        heater_in = 8'h00;
        count_in = INIT_COUNT;
    end

    // A save overwrites both words at once, so the pair never tears.
    always @(posedge clk) begin
        if (nv_save) begin
            heater_in <= heater_out;
            count_in <= count_out;
        end
    end
endmodule

// ===== test_module_memory_map_thermal_emulation.sv
// Purpose: Self-checking bench for the memory map and thermal cut-off block.
// Assumes: Inputs change on the falling edge; the store model answers saves.
// Notes: Random data comes from a fixed-seed LFSR, so every run is identical.
`timescale 1ns/1ps
module test_module_memory_map_thermal_emulation;
    import thermal_map_pkg::*;
    localparam logic [7:0] TYPE_CODE = 8'h3C; // Arbitrary type code value.
    localparam logic [15:0] BOOT_COUNT = 16'h01FF; // Count before power-up.
    localparam logic [15:0] CNT1 = BOOT_COUNT + 16'h0001; // Count after first start.
    localparam logic [15:0] TEMPS [5] = '{16'h4FFF, 16'h5000, 16'h4C00, 16'h4B00, 16'hD800};
    localparam logic [4:0] CUTS = 5'b00110; // Expected cut-off per temperature step.
    logic clk = 1'b0; // Bench clock.
    logic reset = 1'b1; // Synchronous reset.
    acc_req_s acc = '0; // Access request.
    logic [15:0] temp_sample = 16'h1900; // Starts at 25 degrees.
    logic temp_valid = 1'b0; // New reading strobe.
    logic low_power_request_pin = 1'b0; // Pin level.
    logic [7:0] rd_data, nv_heater_in, nv_heater_out; // Byte results.
    logic [15:0] nv_count_in, nv_count_out; // Count words.
    logic rd_valid, nv_save, low_power_mode, cutoff_active, init_done; // Flags.
    heat_drive_s heat; // Heater drive.
    logic [15:0] rnd = 16'h336E; // LFSR state, seed 13166.
    int errors = 0; // Mismatches.
    int check_count = 0; // Comparisons.

    // Clock of 50 ns period.
    always #25 clk = ~clk;

    thermal_map_regs #(.MODULE_TYPE(TYPE_CODE)) thermal_map_regs_inst (.clk(clk),
        .reset(reset), .acc(acc), .rd_data(rd_data), .rd_valid(rd_valid),
        .temp_sample(temp_sample), .temp_valid(temp_valid),
        .low_power_request_pin(low_power_request_pin), .nv_heater_in(nv_heater_in),
        .nv_count_in(nv_count_in), .nv_save(nv_save), .nv_heater_out(nv_heater_out),
        .nv_count_out(nv_count_out), .heat(heat), .low_power_mode(low_power_mode),
        .cutoff_active(cutoff_active), .init_done(init_done));

    nv_store_model #(.INIT_COUNT(BOOT_COUNT)) nv_store_model_inst (.clk(clk),
        .nv_save(nv_save), .heater_out(nv_heater_out), .count_out(nv_count_out),
        .heater_in(nv_heater_in), .count_in(nv_count_in));

    // Galois-free Fibonacci LFSR step with taps 16, 14, 13, 11.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Single compare; case inequality so an unknown never matches.
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run.
    task automatic finish_test();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Each request stands one cycle, then one idle cycle keeps drives apart.
    task automatic load_addr(input logic [7:0] a);
        acc.addr_load = 1'b1;
        acc.addr_value = a;
        @(negedge clk);
        acc = '0;
        @(negedge clk);
    endtask

    // Write one byte at address a.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        load_addr(a);
        acc.wr_stb = 1'b1;
        acc.wr_data = d;
        @(negedge clk);
        acc = '0;
        @(negedge clk);
    endtask

    // Read at the current address; the answer is awaited for a few cycles only.
    task automatic rd_next(input logic [7:0] e);
        int n;
        acc.rd_stb = 1'b1;
        @(negedge clk);
        acc = '0;
        for (n = 0; n < 3 && rd_valid !== 1'b1; n++) begin
            @(negedge clk);
        end
        check_val(16'(rd_valid), 16'h0001);
        check_val(16'(rd_data), 16'(e));
        @(negedge clk);
    endtask

    // Random read at address a.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        load_addr(a);
        rd_next(e);
    endtask

    // Hand the block a new sensor reading and let the cut-off settle.
    task automatic set_temp(input logic [15:0] t);
        temp_sample = t;
        temp_valid = 1'b1;
        @(negedge clk);
        temp_valid = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // Wait, bounded, for the start-up sequence to finish.
    task automatic wait_init();
        int n;
        for (n = 0; n < 8 && init_done !== 1'b1; n++) begin
            @(negedge clk);
        end
        check_val(16'(init_done), 16'h0001);
    endtask

    // Watchdog: the sequence needs a few thousand cycles at most.
    initial begin
        #1000000;
        errors++;
        finish_test();
    end

    // Main sequence.
    initial begin
        int i, n;
        logic [7:0] d;
        logic lp;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        wait_init();
        check_val(nv_count_out, CNT1);
        rd(OFS_MODULE_TYPE, TYPE_CODE);
        rd(OFS_UPPER_ID, TYPE_CODE);
        rd(OFS_PAGE_SEL, RST_PAGE_SEL);
        rd_next(TYPE_CODE);
        // Random readings, then writes aimed at read-only and writable bytes.
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            set_temp(rnd);
            rd(OFS_TEMP_HIGH, rnd[15:8]);
            rd_next(rnd[7:0]);
            wr(OFS_TEMP_LOW, ~rnd[7:0]);
            rd(OFS_TEMP_LOW, rnd[7:0]);
            wr(8'h64, rnd[15:8]);
            rd(8'h64, rnd[15:8]);
        end
        set_temp(16'h1900);
        wr(OFS_PAGE_SEL, PAGE_USER);
        rd(OFS_PLUG_LOW, CNT1[7:0]);
        rd_next(CNT1[15:8]);
        wr(OFS_PLUG_HIGH, ~CNT1[15:8]);
        rd(OFS_PLUG_HIGH, CNT1[15:8]);
        wr(8'hB0, rnd[7:0]);
        rd(8'hB0, rnd[7:0]);
        wr(OFS_PAGE_SEL, 8'h01);
        wr(8'hB0, 8'h55);
        rd(8'hB0, 8'h00);
        wr(OFS_PAGE_SEL, PAGE_EXTRA);
        rnd = lfsr(rnd);
        wr(8'h80, rnd[7:0]);
        wr(8'hFF, rnd[15:8]);
        rd(8'hFF, rnd[15:8]);
        rd_next(rnd[7:0]);
        wr(OFS_PAGE_SEL, PAGE_ID);
        rd(OFS_UPPER_ID, TYPE_CODE);
        // Every combination of the two static spots.
        for (i = 0; i < 4; i++) begin
            d = {i[1:0], 6'h00};
            wr(OFS_HEATER, d);
            check_val(16'(nv_heater_out), 16'(d));
            repeat (3) @(negedge clk);
            check_val(16'({heat.spot_hi, heat.spot_lo}), 16'({d[7], d[6]}));
        end
        // Duty over one full period equals the code, for both ends and a random code.
        for (i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h3F : {2'b00, rnd[5:0]};
            wr(OFS_HEATER, d);
            repeat (3) @(negedge clk);
            n = 0;
            repeat (63) begin
                @(negedge clk);
                if (heat.pwm === 1'b1) begin
                    n++;
                end
            end
            check_val(16'(n), 16'(d));
        end
        // Power mode over all pin, override and set combinations.
        wr(OFS_HEATER, 8'hFF);
        for (i = 0; i < 8; i++) begin
            low_power_request_pin = i[2];
            wr(OFS_POWER_CTRL, {6'h00, i[1:0]});
            repeat (4) @(negedge clk);
            lp = i[0] ? i[1] : i[2];
            check_val(16'(low_power_mode), 16'(lp));
            check_val(16'(heat), lp ? 16'h0000 : 16'h0007);
        end
        low_power_request_pin = 1'b0;
        wr(OFS_POWER_CTRL, 8'h00);
        // Climb to the cut-off, fall through the band, then a negative reading.
        for (i = 0; i < 5; i++) begin
            set_temp(TEMPS[i]);
            check_val(16'(cutoff_active), 16'(CUTS[i]));
            check_val(16'(heat), CUTS[i] ? 16'h0000 : 16'h0007);
        end
        // Reset in mid-run: the stored heater byte must come back.
        wr(OFS_HEATER, 8'h9A);
        repeat (2) @(negedge clk);
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        wait_init();
        check_val(16'(nv_heater_out), 16'h009A);
        check_val(nv_count_out, BOOT_COUNT + 16'h0002);
        rd(OFS_PAGE_SEL, RST_PAGE_SEL);
        repeat (3) @(negedge clk);
        check_val(16'({heat.spot_hi, heat.spot_lo}), 16'h0002);
        finish_test();
    end
endmodule
